// File: dv/laser_control_fault_supervisor_test.sv
// self-checking bench for the laser supervisor
`timescale 1ns/1ps
`include "lcfs_consts.svh"
module laser_control_fault_supervisor_test;
   localparam int INIT = 20;
   localparam int START = 60;
   localparam int CONV = 10;
   localparam int STEP = 4;
   localparam logic [1:0] OK = `LCFS_RESP_OKAY;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [4:0]  faultIn = 5'h00;
   logic        txDisable = 1'b1;
   logic [7:0]  receiveLevelInput = 8'hA0, modTableOffset = 8'h05, biasTableOffset = 8'h03;
   logic [7:0]  modDac, biasFaultThreshold;
   logic        modShut, modRail, modOeN, biasShut, biasRail, biasOeN, loopActive;
   logic        laserKillIn, laserKillOutput, laserKillOeN, rxLosIn, rxLosOut, rxLosOeN;
   logic        txFault, convRun, dataReady;
   logic        extKillEn = 1'b0, extKillLevel = 1'b0, extLosEn = 1'b0, extLosLevel = 1'b0;
   int          mismatches = 0, n_checks = 0, cyc = 0, tConv = -1, tReady = -1;

   lcfs_top #(.INIT_CYCLES(INIT), .START_CYCLES(START), .CONV_CYCLES(CONV), .STEP_CYCLES(STEP))
   u_lcfs_top (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .faultIn, .txDisable, .receiveLevelInput,
      .modTableOffset, .biasTableOffset, .modDac, .modShut, .modRail, .modOeN, .biasShut,
      .biasRail, .biasOeN, .loopActive, .biasFaultThreshold, .laserKillIn,
      .laserKillOutput, .laserKillOeN, .rxLosIn, .rxLosOut, .rxLosOeN, .txFault,
      .convRun, .dataReady);
   lcfs_partner u_lcfs_partner (.clock, .laserKillOutput, .laserKillOeN, .rxLosOut,
      .rxLosOeN, .extKillEn, .extKillLevel, .extLosEn, .extLosLevel, .laserKillIn, .rxLosIn);

   initial begin
      forever #10 clock = ~clock;
   end
   // first-rise stamps, counted in edges after reset release
   always @(posedge clock) begin
      cyc <= rst ? 0 : cyc + 1;
      if (!rst && convRun === 1'b1 && tConv < 0) tConv <= cyc;
      if (!rst && dataReady === 1'b1 && tReady < 0) tReady <= cyc;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic timeout();
      chk(32'h0, 32'h1);
      tally_and_finish();
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   // the bench keeps bready high, so the response edge is the bvalid edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 300; i++) begin
         @(posedge clock);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (i == 300) timeout();
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      int i;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 300; i++) begin
         @(posedge clock);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (i == 300) timeout();
      rv = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask

   task automatic t_powerup();
      rd(`LCFS_OFS_STATUS, OK);
      chkb(cyc >= INIT, 1'b1); // bus stalled through init
      chkb(rv[0], 1'b1); // init flag polled
      rd(`LCFS_OFS_BIASFLT, OK);
      chk(rv, 32'h000000FF); // bias threshold reset
      rd(`LCFS_OFS_BLANK, OK);
      chk(rv, 32'h00000001); // blanking reset
      rd(8'h20, `LCFS_RESP_SLVERR);
      chk(rv, 32'h0); // unmapped read
      wr(8'h20, 32'h0000FFFF, `LCFS_RESP_SLVERR);
      wr(`LCFS_OFS_MODSET, 32'h30, OK);
      rd(`LCFS_OFS_MODSET, OK);
      chk(rv, 32'h30); // setpoint readback
      wt(START);
      chkb(tConv >= INIT - 1 && tConv <= INIT + 3, 1'b1); // conversions after init
      chkb(tReady - tConv >= CONV - 1 && tReady - tConv <= CONV + 2, 1'b1); // first data
      chkb(convRun, 1'b1); // conversions despite disable
      chkb(modShut, 1'b1); // laser held off
      txDisable <= 1'b0;
      wt(10);
      chkb(modOeN, 1'b1); // floats while disabled output
      chkb(biasOeN, 1'b1); // floats while disabled output
      chkb(laserKillOeN, 1'b1); // floats while disabled output
      chkb(loopActive, 1'b0); // loop stays off
      txDisable <= 1'b1;
      $display("test powerup done");
   endtask

   task automatic t_shutdown();
      logic [2:0] k;
      for (int j = 0; j < 8; j++) begin
         k = 3'(j);
         wr(`LCFS_OFS_CTRL, {27'h0, k[0], k, 1'b1}, OK);
         wt(4);
         chkb(modOeN, 1'b0); // driven once enabled
         chkb(biasShut, 1'b1); // bias held off
         chkb(modRail, k[0]); // modulation rail choice
         chkb(biasRail, k[1]); // bias rail, invert ignored
         chkb(laserKillOeN, 1'b0); // pin driven
         chkb(laserKillOutput, k[2]); // pin polarity
      end
      txDisable <= 1'b0;
      wr(`LCFS_OFS_CTRL, 32'h00000809, OK);
      wt(6);
      chkb(laserKillOutput, 1'b1); // software disable activates pin
      chkb(modShut, 1'b1); // laser off
      wr(`LCFS_OFS_CTRL, 32'h00000009, OK);
      wt(8);
      chkb(laserKillOutput, 1'b0); // pin inactive with laser on
      chkb(modShut, 1'b0); // laser started
      $display("test shutdown done");
   endtask

   task automatic t_loop();
      wr(`LCFS_OFS_MODDIR, 32'h5A, OK);
      wr(`LCFS_OFS_CTRL, 32'h00000409, OK);
      wt(4);
      chk({24'h0, modDac}, 32'h35); // setpoint plus offset
      chkb(loopActive, 1'b1); // loop runs with enable
      chk({24'h0, biasFaultThreshold}, 32'h02); // offset wraps
      wr(`LCFS_OFS_CTRL, 32'h00000009, OK);
      wt(4);
      chk({24'h0, modDac}, 32'h30); // no compensation
      chk({24'h0, biasFaultThreshold}, 32'hFF); // nominal only
      wr(`LCFS_OFS_CTRL, 32'h00000209, OK);
      wt(4);
      chk({24'h0, modDac}, 32'h5A); // direct value
      wr(`LCFS_OFS_CTRL, 32'h00000009, OK);
      $display("test loop done");
   endtask

   task automatic t_fault();
      for (int f = 0; f < 4; f++) begin
         wr(`LCFS_OFS_CTRL, {23'h0, f[0], 8'h09}, OK);
         wr(`LCFS_OFS_FMASK, 32'h1F, OK);
         faultIn <= 5'(1 << f);
         wt(8);
         chkb(txFault, 1'b0); // masked source silent
         chkb(modShut, 1'b0); // masked source keeps laser
         wr(`LCFS_OFS_FMASK, 32'h0, OK);
         wt(6);
         chkb(txFault, 1'b1); // unmasked source
         chkb(biasShut, 1'b1); // bias forced off
         chkb(laserKillOutput, f[0]); // pin only when kill enabled
         faultIn <= 5'h00;
         wt(8);
         chkb(txFault, 1'b1); // fault latched
         txDisable <= 1'b1;
         wt(6);
         chkb(txFault, 1'b0); // cleared by toggle
         txDisable <= 1'b0;
         wt(8);
         chkb(modShut, 1'b0); // laser restarts
      end
      $display("test fault done");
   endtask

   task automatic t_blank();
      int i;
      wr(`LCFS_OFS_BLANK, 32'h3, OK);
      txDisable <= 1'b1;
      wt(6);
      faultIn <= 5'h10;
      wt(2);
      txDisable <= 1'b0;
      for (i = 0; i < 100 && txFault !== 1'b1; i++) @(posedge clock);
      if (i == 100) timeout();
      chkb(i >= 3 * STEP && i <= 3 * STEP + 10, 1'b1); // saturation blanked
      faultIn <= 5'h00;
      txDisable <= 1'b1;
      wt(6);
      txDisable <= 1'b0;
      wt(8);
      $display("test blank done");
   endtask

   task automatic t_loss();
      logic [7:0] lv [4] = '{8'h30, 8'h60, 8'h90, 8'h50};
      logic       ex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      wr(`LCFS_OFS_LOSTHR, 32'h00008040, OK);
      for (int j = 0; j < 4; j++) begin
         receiveLevelInput <= lv[j];
         wt(4);
         chkb(rxLosOut, ex[j]); // hysteresis
         rd(`LCFS_OFS_STATUS, OK);
         chkb(rv[3], ex[j]); // pin level reported
      end
      extLosEn <= 1'b1;
      extLosLevel <= 1'b1;
      wr(`LCFS_OFS_CTRL, 32'h00000089, OK);
      wt(4);
      chkb(rxLosOeN, 1'b1); // pin released
      rd(`LCFS_OFS_STATUS, OK);
      chkb(rv[3], 1'b1); // outside level reported
      $display("test loss done");
   endtask

   task automatic t_extfault();
      extKillEn <= 1'b1;
      extKillLevel <= 1'b1;
      wr(`LCFS_OFS_CTRL, 32'h00000069, OK);
      wt(6);
      chkb(laserKillOeN, 1'b1); // pin becomes input
      chkb(txFault, 1'b1); // outside fault ORed
      rd(`LCFS_OFS_STATUS, OK);
      chkb(rv[2], 1'b1); // status fault bit
      extKillLevel <= 1'b0;
      wt(6);
      chkb(txFault, 1'b0); // inactive level
      wr(`LCFS_OFS_CTRL, 32'h00000029, OK);
      wt(6);
      chkb(txFault, 1'b1); // low-active polarity
      $display("test extfault done");
   endtask

   initial begin
      wt(20);
      chkb(modOeN, 1'b1); // floating during reset
      chkb(modShut, 1'b1); // laser off during reset
      rst <= 1'b0;
      t_powerup();
      t_shutdown();
      t_loop();
      t_fault();
      t_blank();
      t_loss();
      t_extfault();
      tally_and_finish();
   end
endmodule // laser_control_fault_supervisor_test

// File: dv/lcfs_partner.sv
// far-side pin model: shared shutdown pin and loss pin with external drivers
`timescale 1ns/1ps
module lcfs_partner (
   input  wire logic clock,
   input  wire logic laserKillOutput,
   input  wire logic laserKillOeN,
   input  wire logic rxLosOut,
   input  wire logic rxLosOeN,
   input  wire logic extKillEn,
   input  wire logic extKillLevel,
   input  wire logic extLosEn,
   input  wire logic extLosLevel,
   output logic      laserKillIn,
   output logic      rxLosIn
);
   logic flip = 1'b0;
   // a released pin with no driver wanders, so nothing may rely on a held value
   always @(posedge clock) begin
      flip <= ~flip;
   end
   // outside faults enter through the shared pin, never by wire-OR on txFault
   assign laserKillIn = !laserKillOeN ? laserKillOutput : (extKillEn ? extKillLevel : flip);
   // outside device drives loss once the comparator lets go
   assign rxLosIn = !rxLosOeN ? rxLosOut : (extLosEn ? extLosLevel : flip);
endmodule // lcfs_partner

// File: hdl/lcfs_consts.svh
// offsets, field positions, reset values and timing figures of the laser supervisor
`ifndef LCFS_CONSTS_SVH
`define LCFS_CONSTS_SVH
`define LCFS_CLK_MHZ        50
`define LCFS_INIT_MS        50
`define LCFS_START_MS       200
`define LCFS_CONV_MS        100
`define LCFS_BLANK_STEP_US  500
`define LCFS_OFS_CTRL       8'h00
`define LCFS_OFS_MODSET     8'h04
`define LCFS_OFS_MODDIR     8'h08
`define LCFS_OFS_FMASK      8'h0C
`define LCFS_OFS_BLANK      8'h10
`define LCFS_OFS_LOSTHR     8'h14
`define LCFS_OFS_BIASFLT    8'h18
`define LCFS_OFS_STATUS     8'h1C
`define LCFS_CTRL_RESET     12'h000
`define LCFS_MODSET_RESET   8'h00
`define LCFS_MODDIR_RESET   8'h00
`define LCFS_FMASK_RESET    5'h00
`define LCFS_BLANK_RESET    8'h01
`define LCFS_LOSTHR_RESET   16'h0000
`define LCFS_BIASFLT_RESET  8'hFF
`define LCFS_SAT_BIT        4
`define LCFS_RESP_OKAY      2'h0
`define LCFS_RESP_SLVERR    2'h2
`endif

// File: hdl/lcfs_pkg.sv
// types shared by the laser supervisor
package lcfs_pkg;
   typedef enum logic [2:0] {
      S_INIT,
      S_OFF,
      S_ON,
      S_FAULT
   } lcfs_state_type;
   typedef struct packed {
      logic softwareTxDisable;
      logic tempCompEnable;
      logic loopCalibrationBit;
      logic killOnFault;
      logic lossComparatorDisable;
      logic externalFaultPolarity;
      logic externalFaultInputSel;
      logic feedbackInvert;
      logic shutdownPinPolarity;
      logic biasOutputReferenceSel;
      logic modOutputReferenceSel;
      logic outputEnable;
   } lcfs_cfg_type;
endpackage

// File: hdl/lcfs_top.sv
// laser control and fault supervisor with its AXI4-Lite register slave
// Behaviour
// - loop on: modulation DAC gets table offset plus modulation setpoint.
// - loop off: modulation DAC gets the direct value, no table.
// - modulation reference bit picks ground or supply as DAC reference.
// - about 50ms init before conversions, bus traffic and status polling.
// - first data ready one conversion period after init ends.
// - output enable zero keeps loop off and outputs floating.
// - shutdown pin floats if enable 0, else polarity picks ground or supply.
// - bias and modulation float if enable 0, else reference bit picks rail.
// - laser starts only after start delay and with transmit disable low.
// - start applies compensation if enabled; loop runs only with enable set.
// - transmit disable at power-up: conversions run, laser held off.
// - any unmasked of five fault sources shuts laser, asserts transmit fault.
// - each fault source can be masked away individually.
// - saturation ignored for programmable 0.5ms-step blanking after turn-on.
// - loss set below assert threshold, cleared above higher clear threshold.
// - loss disable turns comparator off and releases the loss pin.
// - status reports loss pin level, whoever drives it.
// - bias fault threshold gets temperature table offset added.
// - fault forces bias and modulation off; shutdown pin only if enabled.
// - select 0: shared pin is push-pull shutdown, active when laser off.
// - select 1: shared pin is external fault input ORed into transmit fault.
// - fault held until transmit disable toggles.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "lcfs_consts.svh"
module lcfs_top #(
   parameter int INIT_CYCLES  = `LCFS_INIT_MS * 1000 * `LCFS_CLK_MHZ,
   parameter int START_CYCLES = `LCFS_START_MS * 1000 * `LCFS_CLK_MHZ,
   parameter int CONV_CYCLES  = `LCFS_CONV_MS * 1000 * `LCFS_CLK_MHZ,
   parameter int STEP_CYCLES  = `LCFS_BLANK_STEP_US * `LCFS_CLK_MHZ
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [4:0]  faultIn,
   input  wire logic        txDisable,
   input  wire logic [7:0]  receiveLevelInput,
   input  wire logic [7:0]  modTableOffset,
   input  wire logic [7:0]  biasTableOffset,
   output logic [7:0]       modDac,
   output logic             modShut,
   output logic             modRail,
   output logic             modOeN,
   output logic             biasShut,
   output logic             biasRail,
   output logic             biasOeN,
   output logic             loopActive,
   output logic [7:0]       biasFaultThreshold,
   input  wire logic        laserKillIn,
   output logic             laserKillOutput,
   output logic             laserKillOeN,
   input  wire logic        rxLosIn,
   output logic             rxLosOut,
   output logic             rxLosOeN,
   output logic             txFault,
   output logic             convRun,
   output logic             dataReady
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // pins pass two flops; stage one feeds stage two only
   logic [7:0] asyncIn;
   logic [7:0] syncA;
   logic [7:0] syncB;
   assign asyncIn = {rxLosIn, laserKillIn, txDisable, faultIn};
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_sync
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               syncA[gi] <= 1'b0;
               syncB[gi] <= 1'b0;
            end else begin
               syncA[gi] <= asyncIn[gi];
               syncB[gi] <= syncA[gi];
            end
         end
      end
   endgenerate
   wire [4:0] faultSync = syncB[4:0];
   wire       txDisSync = syncB[5];
   wire       killInSync = syncB[6];
   wire       rxLosPin  = syncB[7];

   // registers
   lcfs_pkg::lcfs_cfg_type cfg;
   logic [7:0]  modSetpoint;
   logic [7:0]  modDirect;
   logic [4:0]  faultMask;
   logic [7:0]  blankSteps;
   logic [15:0] lossThr;
   logic [7:0]  biasFaultNominal;

   // power-on sequencing
   logic [31:0] initCnt;
   logic [31:0] startCnt;
   logic [31:0] convCnt;
   logic        initDone;
   logic        startDone;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         initCnt   <= 32'h0;
         startCnt  <= 32'h0;
         convCnt   <= 32'h0;
         initDone  <= 1'b0;
         startDone <= 1'b0;
         convRun   <= 1'b0;
         dataReady <= 1'b0;
      end else begin
         if (!initDone) initCnt <= initCnt + 32'h1;
         if (initCnt == INIT_CYCLES - 1) initDone <= 1'b1;
         convRun <= initDone;
         if (convRun && !dataReady) convCnt <= convCnt + 32'h1;
         if (convCnt == CONV_CYCLES - 1) dataReady <= 1'b1;
         if (!startDone) startCnt <= startCnt + 32'h1;
         if (startCnt == START_CYCLES - 1) startDone <= 1'b1;
      end
   end

   // laser state
   lcfs_pkg::lcfs_state_type state;
   lcfs_pkg::lcfs_state_type next_state;
   logic [4:0]  faultLatched;
   logic [31:0] stepCnt;
   logic [7:0]  stepNum;
   logic        txDisPrev;
   wire blankDone = (stepNum >= blankSteps);
   wire [4:0] faultLive = faultSync & ~faultMask;
   wire [4:0] faultNow = {faultLive[4] & blankDone, faultLive[3:0]};
   wire laserOffReq = txDisSync | cfg.softwareTxDisable;
   wire txDisRise = txDisSync & ~txDisPrev;
   always_comb begin
      next_state = state;
      case (state)
         lcfs_pkg::S_INIT:
            if (startDone) next_state = lcfs_pkg::S_OFF;
         lcfs_pkg::S_OFF:
            if (!laserOffReq) next_state = lcfs_pkg::S_ON;
         lcfs_pkg::S_ON:
            if (|faultNow) next_state = lcfs_pkg::S_FAULT;
            else if (laserOffReq) next_state = lcfs_pkg::S_OFF;
         lcfs_pkg::S_FAULT:
            if (txDisRise) next_state = lcfs_pkg::S_OFF;
         default:
            next_state = lcfs_pkg::S_INIT;
      endcase
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state        <= lcfs_pkg::S_INIT;
         faultLatched <= 5'h00;
         txDisPrev    <= 1'b0;
      end else begin
         state     <= next_state;
         txDisPrev <= txDisSync;
         if (state == lcfs_pkg::S_ON && |faultNow) faultLatched <= faultNow;
         else if (state == lcfs_pkg::S_FAULT && txDisRise) faultLatched <= 5'h00;
      end
   end
   // blanking counts whole 0.5ms steps from turn-on; zero steps means no blanking
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stepCnt <= 32'h0;
         stepNum <= 8'h00;
      end else if (state != lcfs_pkg::S_ON) begin
         stepCnt <= 32'h0;
         stepNum <= 8'h00;
      end else if (!blankDone) begin
         stepCnt <= (stepCnt == STEP_CYCLES - 1) ? 32'h0 : stepCnt + 32'h1;
         if (stepCnt == STEP_CYCLES - 1) stepNum <= stepNum + 8'h01;
      end
   end

   // output drive
   wire laserOn = (state == lcfs_pkg::S_ON);
   wire extFault = cfg.externalFaultInputSel &
                   (killInSync == cfg.externalFaultPolarity);
   wire inFault = (state == lcfs_pkg::S_FAULT);
   wire [7:0] modOffset = cfg.tempCompEnable ? modTableOffset : 8'h00;
   wire [7:0] biasOffset = cfg.tempCompEnable ? biasTableOffset : 8'h00;
   wire loopOn = cfg.outputEnable & ~cfg.loopCalibrationBit;
   wire [7:0] next_modDac = loopOn ? modSetpoint + modOffset
                                   : modDirect;
   // shutdown pin is active whenever the laser is off, faults only if enabled
   wire killActive = (state == lcfs_pkg::S_INIT) | (state == lcfs_pkg::S_OFF) | laserOffReq |
                     (inFault & cfg.killOnFault);
   wire killDrive = cfg.outputEnable & ~cfg.externalFaultInputSel;
   // loss comparator keeps its state between the two thresholds
   wire losSet = receiveLevelInput < lossThr[7:0];
   wire losClr = receiveLevelInput > lossThr[15:8];
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         modDac             <= 8'h00;
         modShut            <= 1'b1;
         modRail            <= 1'b0;
         modOeN             <= 1'b1;
         biasShut           <= 1'b1;
         biasRail           <= 1'b0;
         biasOeN            <= 1'b1;
         loopActive         <= 1'b0;
         biasFaultThreshold <= 8'h00;
         laserKillOutput    <= 1'b0;
         laserKillOeN       <= 1'b1;
         rxLosOut           <= 1'b0;
         rxLosOeN           <= 1'b1;
         txFault            <= 1'b0;
      end else begin
         modDac   <= next_modDac;
         modShut  <= ~laserOn;
         modRail  <= cfg.modOutputReferenceSel;
         modOeN   <= ~cfg.outputEnable;
         biasShut <= ~laserOn;
         biasRail <= cfg.biasOutputReferenceSel;
         biasOeN  <= ~cfg.outputEnable;
         loopActive <= laserOn & cfg.outputEnable;
         biasFaultThreshold <= biasFaultNominal + biasOffset;
         laserKillOutput <= killActive ? cfg.shutdownPinPolarity
                                       : ~cfg.shutdownPinPolarity;
         laserKillOeN <= ~killDrive;
         if (cfg.lossComparatorDisable) rxLosOut <= 1'b0;
         else if (losSet) rxLosOut <= 1'b1;
         else if (losClr) rxLosOut <= 1'b0;
         rxLosOeN <= cfg.lossComparatorDisable;
         txFault  <= inFault | extFault;
      end
   end

   // AXI4-Lite slave; stalls until init ends
   function automatic logic [31:0] merge(input logic [31:0] oldV,
                                         input logic [31:0] newV,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = oldV;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) res[b*8 +: 8] = newV[b*8 +: 8];
      end
      return res;
   endfunction
   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= `LCFS_OFS_STATUS;
   endfunction
   wire wrGo = initDone & s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
               ~s_axi_bvalid;
   wire rdGo = initDone & s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   wire [31:0] wm = merge(32'h0, s_axi_wdata, s_axi_wstrb);
   wire [31:0] statusWord = {21'h0, extFault, faultLatched, laserOn,
                             rxLosPin, txFault, dataReady, initDone};
   logic [31:0] rdMux;
   always_comb begin
      case (s_axi_araddr)
         `LCFS_OFS_CTRL:    rdMux = {20'h0, cfg};
         `LCFS_OFS_MODSET:  rdMux = {24'h0, modSetpoint};
         `LCFS_OFS_MODDIR:  rdMux = {24'h0, modDirect};
         `LCFS_OFS_FMASK:   rdMux = {27'h0, faultMask};
         `LCFS_OFS_BLANK:   rdMux = {24'h0, blankSteps};
         `LCFS_OFS_LOSTHR:  rdMux = {16'h0, lossThr};
         `LCFS_OFS_BIASFLT: rdMux = {24'h0, biasFaultNominal};
         `LCFS_OFS_STATUS:  rdMux = statusWord;
         default:           rdMux = 32'h0;
      endcase
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_awready    <= 1'b0;
         s_axi_wready     <= 1'b0;
         s_axi_bvalid     <= 1'b0;
         s_axi_bresp      <= `LCFS_RESP_OKAY;
         s_axi_arready    <= 1'b0;
         s_axi_rvalid     <= 1'b0;
         s_axi_rdata      <= 32'h0;
         s_axi_rresp      <= `LCFS_RESP_OKAY;
         cfg              <= `LCFS_CTRL_RESET;
         modSetpoint      <= `LCFS_MODSET_RESET;
         modDirect        <= `LCFS_MODDIR_RESET;
         faultMask        <= `LCFS_FMASK_RESET;
         blankSteps       <= `LCFS_BLANK_RESET;
         lossThr          <= `LCFS_LOSTHR_RESET;
         biasFaultNominal <= `LCFS_BIASFLT_RESET;
      end else begin
         s_axi_awready <= wrGo;
         s_axi_wready  <= wrGo;
         s_axi_arready <= rdGo;
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         else if (wrGo) s_axi_bvalid <= 1'b1;
         if (wrGo) s_axi_bresp <= mapped(s_axi_awaddr) ? `LCFS_RESP_OKAY
                                                       : `LCFS_RESP_SLVERR;
         if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
         else if (rdGo) s_axi_rvalid <= 1'b1;
         if (rdGo) begin
            s_axi_rdata <= rdMux;
            s_axi_rresp <= mapped(s_axi_araddr) ? `LCFS_RESP_OKAY
                                                : `LCFS_RESP_SLVERR;
         end
         if (wrGo) begin
            case (s_axi_awaddr)
               `LCFS_OFS_CTRL:
                  cfg <= 12'(merge({20'h0, cfg}, wm, s_axi_wstrb));
               `LCFS_OFS_MODSET:  if (s_axi_wstrb[0]) modSetpoint <= wm[7:0];
               `LCFS_OFS_MODDIR:  if (s_axi_wstrb[0]) modDirect <= wm[7:0];
               `LCFS_OFS_FMASK:   if (s_axi_wstrb[0]) faultMask <= wm[4:0];
               `LCFS_OFS_BLANK:   if (s_axi_wstrb[0]) blankSteps <= wm[7:0];
               `LCFS_OFS_LOSTHR:
                  lossThr <= 16'(merge({16'h0, lossThr}, wm, s_axi_wstrb));
               `LCFS_OFS_BIASFLT: if (s_axi_wstrb[0]) biasFaultNominal <= wm[7:0];
               default: ;
            endcase
         end
      end
   end

   chk_no_bus_early: assert property (!initDone |-> !s_axi_awready && !s_axi_arready)
      else $error("bus accepted before init end");
   chk_data_ready: assert property ($rose(dataReady) |-> convRun && $past(convRun, 2))
      else $error("data ready without conversions");
   chk_float_oe: assert property (!cfg.outputEnable |=>
                                  modOeN && biasOeN && laserKillOeN)
      else $error("outputs driven with enable low");
   chk_fault_kill: assert property (state == lcfs_pkg::S_ON && |faultNow
                                    |=> ##1 txFault && modShut)
      else $error("fault did not shut laser");
   chk_mask_quiet: assert property (state == lcfs_pkg::S_ON && faultLive == 5'h00
                                    |=> state != lcfs_pkg::S_FAULT)
      else $error("masked fault shut laser");
   chk_sat_blank: assert property (state == lcfs_pkg::S_ON && !blankDone &&
                                   faultLive == 5'h10 |=> state != lcfs_pkg::S_FAULT)
      else $error("saturation not blanked");
   chk_fault_hold: assert property (inFault && !txDisRise |=> inFault)
      else $error("fault released without toggle");
   chk_los_release: assert property (cfg.lossComparatorDisable |=> rxLosOeN)
      else $error("loss pin driven while disabled");
   chk_start_wait: assert property (!startDone |=> !laserOn)
      else $error("laser on before start delay");
   chk_kill_level: assert property (laserOffReq && killDrive |=>
                                    laserKillOutput == $past(cfg.shutdownPinPolarity))
      else $error("shutdown pin level wrong");
endmodule // lcfs_top
